// ===== dv/bsl_human.sv
`timescale 1ns/1ps
module bsl_human (
  input  wire logic clk_sys,               // system clock
  output      logic pushbutton_input,      // button, pulled low when released
  input  wire logic status_indicator_line  // led being watched
);
  int   rises;
  logic led_q;
  initial begin
    pushbutton_input = 1'b0;
    rises            = 0;
    led_q            = 1'b0;
  end
  always @(posedge clk_sys) begin
    led_q <= status_indicator_line;
    if (status_indicator_line && !led_q) begin
      rises <= rises + 1;
    end
  end
  // one press: hi ticks held, lo ticks released; pull-down gives low
  task automatic press(input int hi, input int lo);
    @(posedge clk_sys);
    pushbutton_input <= 1'b1;
    repeat (hi) @(posedge clk_sys);
    pushbutton_input <= 1'b0;
    repeat (lo) @(posedge clk_sys);
  endtask
endmodule

// ===== dv/tb_button_sequence_led_indicator.sv
`timescale 1ns/1ps
module tb_button_sequence_led_indicator;
  import bsl_pkg::*;
  // one clock per tick keeps the 30000-tick hold inside the run
  localparam int TICK = 1;
  logic        clk_sys, rst_n, pushbutton_input, is_admin, key_set, xfer_active;
  logic        pkt_activity, status_indicator_line, join_start, join_cancel;
  logic        genkey_commit, key_test, factory_restore;
  logic [15:0] restore_baud;
  logic [2:0]  ev;
  logic [4:0]  cmds;
  int          cnt[5], base[5], miscompares, comparisons, r0, n;

  assign cmds = {factory_restore, key_test, genkey_commit, join_cancel, join_start};

  bsl_top #(.TICK_CYC(TICK)) DUT (
    .clk_sys(clk_sys), .rst_n(rst_n), .pushbutton_input(pushbutton_input),
    .is_admin(is_admin), .key_set(key_set), .join_done(ev[0]),
    .xfer_active(xfer_active), .xfer_done(ev[1]), .xfer_fail(ev[2]),
    .pkt_activity(pkt_activity), .status_indicator_line(status_indicator_line),
    .join_start(join_start), .join_cancel(join_cancel), .genkey_commit(genkey_commit),
    .key_test(key_test), .factory_restore(factory_restore), .restore_baud(restore_baud));

  bsl_human human (.clk_sys(clk_sys), .pushbutton_input(pushbutton_input),
                   .status_indicator_line(status_indicator_line));

  // cycles high per command; a one-cycle pulse adds exactly one
  always @(posedge clk_sys) begin
    for (int i = 0; i < 5; i++) cnt[i] += cmds[i];
  end

  task automatic check(input string what, input logic [15:0] seen, input logic [15:0] exp);
    comparisons++;
    if (seen !== exp) begin
      miscompares++;
      $display("MISMATCH %s expected %0h seen %0h", what, exp, seen);
    end
  endtask

  task automatic chk_cmds(input string what, input logic [4:0] exp);
    for (int i = 0; i < 5; i++) begin
      check(what, 16'(cnt[i] - base[i]), 16'(exp[i]));
      base[i] = cnt[i];
    end
    $display("test %s ended", what);
  endtask

  task automatic idle(input int t);
    repeat (t) @(posedge clk_sys);
  endtask

  task automatic wait_cmd(input int i, input int bound);
    for (int k = 0; k < bound && cnt[i] == base[i]; k++) @(posedge clk_sys);
  endtask

  task automatic blinks(input string what, input int t, input int lo, input int hi);
    r0 = human.rises;
    idle(t);
    check(what, 16'(human.rises - r0 >= lo && human.rises - r0 <= hi), 16'h0001);
  endtask

  task automatic event_pulse(input logic [2:0] v);
    ev <= v;
    @(posedge clk_sys);
    ev <= 3'h0;
  endtask

  function automatic int quick_n(input logic adm, input logic set);
    return !set ? 1 : (adm ? 3 : 2);
  endfunction

  task automatic conclude();
    $display("comparisons %0d miscompares %0d", comparisons, miscompares);
    if (miscompares == 0 && comparisons > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask

  initial begin
    clk_sys = 1'b0;
    forever #5 clk_sys = ~clk_sys;
  end

  // whole sequence needs about 106k cycles; the 30000-tick hold dominates
  initial begin
    #1_100_000;
    miscompares++;
    conclude();
  end

  initial begin
    rst_n        = 1'b0;
    is_admin     = 1'b0;
    key_set      = 1'b0;
    xfer_active  = 1'b0;
    pkt_activity = 1'b0;
    ev           = 3'h0;
    miscompares  = 0;
    comparisons  = 0;
    n            = $urandom(95327);
    repeat (4) @(posedge clk_sys);
    rst_n <= 1'b1;
    @(posedge clk_sys);
    check("restore_baud", restore_baud, 16'h2580);
    chk_cmds("reset", 5'h00);
    fork
      human.press(500, 2300);
      begin
        idle(300);
        check("led held", {15'h0000, status_indicator_line}, 16'h0001);
      end
    join
    chk_cmds("node join", 5'h01);
    blinks("node search", 2500, 2, 3);
    human.press(300, 0);
    wait_cmd(1, 2500);
    blinks("cancel", 2000, 1, 2);
    blinks("cancel once", 1000, 0, 0);
    chk_cmds("cancel", 5'h02);
    is_admin <= 1'b1;
    human.press(300, 2300);
    chk_cmds("admin join", 5'h01);
    blinks("admin search", 3900, 5, 7);
    event_pulse(3'h1);
    blinks("joined", 2000, 0, 0);
    for (int i = 1; i < 3; i++) begin
      event_pulse(3'(1 << i));
      blinks("report", i == 1 ? 6200 : 3200, i == 1 ? 6 : 3, i == 1 ? 6 : 3);
    end
    xfer_active <= 1'b1;
    blinks("xfer", 3000, 2, 4);
    xfer_active <= 1'b0;
    idle(1000);
    pkt_activity <= 1'b1;
    idle(4);
    check("pkt on", {15'h0000, status_indicator_line}, 16'h0001);
    pkt_activity <= 1'b0;
    idle(4);
    check("pkt off", {15'h0000, status_indicator_line}, 16'h0000);
    for (int k = 0; k < 3; k++) begin
      key_set  <= (k != 0);
      is_admin <= (k == 2);
      for (int p = 0; p < 3; p++) human.press(150 + $urandom % 750, p < 2 ? 150 + $urandom % 750 : 0);
      wait_cmd(3, 2500);
      n = quick_n(k == 2, k != 0);
      blinks("key result", 1200 + 1000 * n, 3 * n, 3 * n);
      chk_cmds("key test", 5'h08);
    end
    human.press(50, 2500);
    human.press(300, 2300);
    chk_cmds("mistimed", 5'h00);
    idle(3200);
    human.press(300, 2300);
    chk_cmds("after lockout", 5'h01);
    event_pulse(3'h1);
    for (int p = 0; p < 4; p++) human.press(300, 300);
    fork
      human.press(5000, 0);
      begin
        idle(3300);
        blinks("restore groups", 1600, 2, 4);
      end
    join
    wait_cmd(4, 100);
    chk_cmds("restore", 5'h10);
    check("restore_baud", restore_baud, 16'h2580);
    idle(100);
    fork
      human.press(31500, 0);
      begin
        idle(30100);
        blinks("long hold", 1300, 1, 3);
      end
    join
    wait_cmd(2, 100);
    chk_cmds("genkey", 5'h04);
    conclude();
  end
endmodule

// ===== verilog/bsl_blinker.sv
`timescale 1ns/1ps
module bsl_blinker
  import bsl_pkg::*;
(
  bsl_if.blk bus  // pattern request in, led and done out
);
  typedef struct packed {
    bsl_bst_e   bst;
    bsl_pat_s   cur;
    logic [1:0] idx;
    logic [2:0] rep;
    logic [15:0] tmr;
    logic       led;
    logic       done;
  } bsl_blk_s;

  bsl_blk_s st;
  bsl_blk_s next_st;
  logic [2:0]  elems;
  logic [15:0] step;

  function automatic logic [15:0] dur_of(input logic slow, input logic on);
    if (slow) begin
      return on ? 16'(`BSL_SLOW_ON_MS / `BSL_TICK_MS) : 16'(`BSL_SLOW_OFF_MS / `BSL_TICK_MS);
    end
    return on ? 16'(`BSL_QUICK_ON_MS / `BSL_TICK_MS) : 16'(`BSL_QUICK_OFF_MS / `BSL_TICK_MS);
  endfunction

  assign elems = {2'h0, st.cur.lead_slow} + {1'b0, st.cur.quick_n};
  assign step  = st.tmr + 16'h0001;

  always_comb begin
    next_st      = st;
    next_st.done = 1'b0;
    // any change of request restarts from the first blink
    if (bus.pat != st.cur) begin
      next_st.cur = bus.pat;
      next_st.idx = 2'h0;
      next_st.rep = 3'h0;
      next_st.tmr = 16'h0000;
      next_st.bst = (bus.pat.id == P_NONE) ? B_IDLE : B_ON;
      next_st.led = (bus.pat.id != P_NONE);
    end else if (bus.tick) begin
      next_st.tmr = step;
      unique case (st.bst)
        B_IDLE: next_st.tmr = 16'h0000;
        B_ON: begin
          if (step >= dur_of(st.cur.lead_slow && st.idx == 2'h0, 1'b1)) begin
            next_st.bst = B_OFF;
            next_st.led = 1'b0;
            next_st.tmr = 16'h0000;
          end
        end
        B_OFF: begin
          if (step >= dur_of(st.cur.lead_slow && st.idx == 2'h0, 1'b0)) begin
            next_st.tmr = 16'h0000;
            if ({1'b0, st.idx} + 3'h1 < elems) begin
              next_st.idx = st.idx + 2'h1;
              next_st.bst = B_ON;
              next_st.led = 1'b1;
            end else begin
              next_st.bst = B_GAP;
            end
          end
        end
        B_GAP: begin
          // slow-only patterns run without the group gap
          if (st.cur.quick_n == 2'h0 || step >= 16'(`BSL_GROUP_GAP_MS / `BSL_TICK_MS)) begin
            next_st.tmr = 16'h0000;
            next_st.idx = 2'h0;
            next_st.rep = st.rep + 3'h1;
            if (st.cur.reps != 3'h0 && st.rep + 3'h1 == st.cur.reps) begin
              next_st.bst  = B_IDLE;
              next_st.done = 1'b1;
            end else begin
              next_st.bst = B_ON;
              next_st.led = 1'b1;
            end
          end
        end
      endcase
    end
  end

  always_ff @(posedge bus.clk_sys) begin
    if (!bus.rst_n) begin
      st <= '{bst: B_IDLE, cur: '0, idx: 2'h0, rep: 3'h0, tmr: 16'h0000,
              led: 1'b0, done: 1'b0};
    end else begin
      st <= next_st;
    end
  end

  assign bus.led  = st.led;
  assign bus.done = st.done;

  default clocking cb @(posedge bus.clk_sys); endclocking
  default disable iff (!bus.rst_n);

  a_blk_idle_dark: assert property (st.bst == B_IDLE |-> !st.led)
    else $error("indicator lit while blinker idle");
  a_blk_done_count: assert property (st.done |-> st.cur.reps != 3'h0
                                     && st.rep == st.cur.reps && $past(st.bst) == B_GAP)
    else $error("pattern ended before its repeat count");
endmodule

// ===== verilog/bsl_debounce.sv
`timescale 1ns/1ps
module bsl_debounce
  import bsl_pkg::*;
(
  input wire logic raw,  // pushbutton pin, active high
  bsl_if.deb       bus   // tick in, clean level out
);
  typedef struct packed {
    logic       s1;
    logic       s2;
    logic       level;
    logic [7:0] cnt;
  } bsl_deb_s;

  localparam logic [7:0] DEB_T = 8'(`BSL_DEBOUNCE_MS / `BSL_TICK_MS);

  bsl_deb_s st;
  bsl_deb_s next_st;

  // level follows the synchronised pin only after it has held still
  always_comb begin
    next_st    = st;
    next_st.s1 = raw;
    next_st.s2 = st.s1;
    if (st.s2 == st.level) begin
      next_st.cnt = 8'h00;
    end else if (bus.tick) begin
      if (st.cnt + 8'h01 >= DEB_T) begin
        next_st.level = st.s2;
        next_st.cnt   = 8'h00;
      end else begin
        next_st.cnt = st.cnt + 8'h01;
      end
    end
  end

  always_ff @(posedge bus.clk_sys) begin
    if (!bus.rst_n) begin
      st <= '0;
    end else begin
      st <= next_st;
    end
  end

  assign bus.btn = st.level;

  default clocking cb @(posedge bus.clk_sys); endclocking
  default disable iff (!bus.rst_n);

  a_deb_settled: assert property ($changed(st.level) |-> $past(st.s2) == st.level
                                  && $past(st.cnt) == DEB_T - 8'h01)
    else $error("debounced level moved without a settled count");
endmodule

// ===== verilog/bsl_if.sv
`timescale 1ns/1ps
interface bsl_if
  import bsl_pkg::*;
(
  input wire logic clk_sys,  // system clock
  input wire logic rst_n     // sync reset, active low
);
  logic     tick;  // 1 ms enable pulse
  logic     btn;   // debounced button level
  bsl_pat_s pat;   // requested indicator pattern
  logic     led;   // pattern output level
  logic     done;  // finite pattern finished

  modport deb (input clk_sys, rst_n, tick, output btn);
  modport blk (input clk_sys, rst_n, tick, pat, output led, done);
  modport ctl (input btn, led, done, output tick, pat);
endinterface

// ===== verilog/bsl_pkg.sv
package bsl_pkg;
`include "bsl_regs.svh"

  typedef enum logic [3:0] {
    P_NONE = 4'h0, P_ADMIN_JOIN = 4'h1, P_NODE_JOIN = 4'h2, P_XFER = 4'h3,
    P_XFER_DONE = 4'h4, P_CANCEL = 4'h5, P_FAIL = 4'h6, P_LONGHOLD = 4'h7,
    P_KEY_NONE = 4'h8, P_KEY_NODE = 4'h9, P_KEY_ADMIN = 4'hA, P_RESTORE = 4'hB
  } bsl_pid_e;

  // reps of zero means repeat until the pattern is withdrawn
  typedef struct packed {
    bsl_pid_e   id;
    logic       lead_slow;
    logic [1:0] quick_n;
    logic [2:0] reps;
  } bsl_pat_s;

  typedef enum logic [5:0] {
    D_IDLE = 6'h01, D_HIGH = 6'h02, D_LOW = 6'h04,
    D_LOCK = 6'h08, D_HOLD = 6'h10, D_RESTORE = 6'h20
  } bsl_dst_e;

  typedef enum logic [3:0] {
    B_IDLE = 4'h1, B_ON = 4'h2, B_OFF = 4'h4, B_GAP = 4'h8
  } bsl_bst_e;

  function automatic bsl_pat_s bsl_pat_of(input bsl_pid_e id);
    bsl_pat_s p;
    p = '{id: id, lead_slow: 1'b0, quick_n: 2'h0, reps: 3'h0};
    case (id)
      P_ADMIN_JOIN:        p.quick_n = 2'h2;
      P_NODE_JOIN, P_XFER: p.quick_n = 2'h1;
      P_XFER_DONE: begin
        p.lead_slow = 1'b1;
        p.reps      = 3'(`BSL_XFER_DONE_REPS);
      end
      P_CANCEL: begin
        p.quick_n = 2'h2;
        p.reps    = 3'h1;
      end
      P_FAIL: begin
        p.lead_slow = 1'b1;
        p.reps      = 3'(`BSL_FAIL_REPS);
      end
      P_LONGHOLD: begin
        p.lead_slow = 1'b1;
        p.quick_n   = 2'h2;
      end
      P_KEY_NONE, P_KEY_NODE, P_KEY_ADMIN: begin
        p.quick_n = 2'(id - P_KEY_NONE + 4'h1);
        p.reps    = 3'(`BSL_KEYTEST_REPS);
      end
      P_RESTORE: p.quick_n = 2'h3;
      default:   p = '{id: P_NONE, lead_slow: 1'b0, quick_n: 2'h0, reps: 3'h0};
    endcase
    return p;
  endfunction
endpackage

// ===== verilog/bsl_regs.svh
`ifndef BSL_REGS_SVH
`define BSL_REGS_SVH
// timebase
`define BSL_CLK_PERIOD_NS    10
`define BSL_TICK_MS          1
// button timing, ms unless named _S
`define BSL_DEBOUNCE_MS      20
`define BSL_BRIEF_MIN_MS     100
`define BSL_BRIEF_MAX_MS     2000
`define BSL_RESTORE_HOLD_S   3
`define BSL_LOCKOUT_S        3
`define BSL_GENKEY_HOLD_S    30
`define BSL_JOIN_WINDOW_S    30
// indicator timing, ms
`define BSL_QUICK_ON_MS      150
`define BSL_QUICK_OFF_MS     150
`define BSL_SLOW_ON_MS       500
`define BSL_SLOW_OFF_MS      500
`define BSL_GROUP_GAP_MS     700
// counts and default baud rate
`define BSL_XFER_DONE_REPS   6
`define BSL_FAIL_REPS        3
`define BSL_KEYTEST_REPS     3
`define BSL_RESTORE_PULSES   4
`define BSL_KEYTEST_PULSES   3
`define BSL_DEFAULT_BAUD     9600
`endif

// ===== verilog/bsl_top.sv
`timescale 1ns/1ps
module bsl_top
  import bsl_pkg::*;
#(
  parameter int TICK_CYC = `BSL_TICK_MS * 1000000 / `BSL_CLK_PERIOD_NS
) (
  input  wire logic        clk_sys,               // 100 MHz system clock
  input  wire logic        rst_n,                 // sync reset, active low
  input  wire logic        pushbutton_input,      // button, high when pressed
  input  wire logic        is_admin,              // unit is network administrator
  input  wire logic        key_set,               // network key and address present
  input  wire logic        join_done,             // join finished, pulse
  input  wire logic        xfer_active,           // key transfer running, level
  input  wire logic        xfer_done,             // key transfer finished, pulse
  input  wire logic        xfer_fail,             // share or get key failed, pulse
  input  wire logic        pkt_activity,          // packet on air, level
  output      logic        status_indicator_line, // led drive, high = on
  output      logic        join_start,            // start join, pulse
  output      logic        join_cancel,           // abort join, pulse
  output      logic        genkey_commit,         // generate key and address, pulse
  output      logic        key_test,              // run key test, pulse
  output      logic        factory_restore,       // load defaults and restart, pulse
  output      logic [15:0] restore_baud           // serial rate to use after restore
);
  localparam logic [16:0] DIV_LAST  = 17'(TICK_CYC - 1);
  localparam logic [15:0] BRIEF_MIN = 16'(`BSL_BRIEF_MIN_MS / `BSL_TICK_MS);
  localparam logic [15:0] BRIEF_MAX = 16'(`BSL_BRIEF_MAX_MS / `BSL_TICK_MS);
  localparam logic [15:0] RESTORE_T = 16'(`BSL_RESTORE_HOLD_S * 1000 / `BSL_TICK_MS);
  localparam logic [15:0] LOCKOUT_T = 16'(`BSL_LOCKOUT_S * 1000 / `BSL_TICK_MS);
  localparam logic [15:0] GENKEY_T  = 16'(`BSL_GENKEY_HOLD_S * 1000 / `BSL_TICK_MS);
  localparam logic [15:0] JOIN_T    = 16'(`BSL_JOIN_WINDOW_S * 1000 / `BSL_TICK_MS);

  typedef struct packed {
    bsl_dst_e    dst;
    logic [15:0] ms;
    logic [2:0]  pulses;
    logic [16:0] div;
    logic        tick;
    logic        join_busy;
    logic [15:0] join_ms;
    bsl_pid_e    shot;
    logic        join_start;
    logic        join_cancel;
    logic        genkey;
    logic        key_test;
    logic        restore;
    logic [15:0] baud;
    logic        led;
  } bsl_top_s;

  bsl_top_s st;
  bsl_top_s next_st;
  bsl_pid_e pick;

  bsl_if u_if (
    .clk_sys (clk_sys),
    .rst_n   (rst_n)
  );

  bsl_debounce u_deb (
    .raw (pushbutton_input),
    .bus (u_if)
  );

  bsl_blinker u_blk (
    .bus (u_if)
  );

  function automatic bsl_pid_e keytest_id(input logic set, input logic admin);
    if (!set) begin
      return P_KEY_NONE;
    end
    return admin ? P_KEY_ADMIN : P_KEY_NODE;
  endfunction

  // held gestures outrank one-shot reports, which outrank level activity
  always_comb begin
    if (st.dst == D_RESTORE) begin
      pick = P_RESTORE;
    end else if (st.dst == D_HOLD) begin
      pick = P_LONGHOLD;
    end else if (st.shot != P_NONE) begin
      pick = st.shot;
    end else if (xfer_active) begin
      pick = P_XFER;
    end else if (st.join_busy) begin
      pick = is_admin ? P_ADMIN_JOIN : P_NODE_JOIN;
    end else begin
      pick = P_NONE;
    end
  end

  assign u_if.tick = st.tick;
  assign u_if.pat  = bsl_pat_of(pick);

  always_comb begin
    next_st             = st;
    next_st.join_start  = 1'b0;
    next_st.join_cancel = 1'b0;
    next_st.genkey      = 1'b0;
    next_st.key_test    = 1'b0;
    next_st.restore     = 1'b0;
    next_st.tick        = 1'b0;
    if (st.div == DIV_LAST) begin
      next_st.div  = 17'h0_0000;
      next_st.tick = 1'b1;
    end else begin
      next_st.div = st.div + 17'h0_0001;
    end
    if (st.tick && st.ms != 16'hFFFF) begin
      next_st.ms = st.ms + 16'h0001;
    end

    // join search window
    if (st.join_busy && st.tick) begin
      next_st.join_ms = st.join_ms + 16'h0001;
    end
    if (st.join_busy && (join_done || xfer_done || xfer_fail || st.join_ms >= JOIN_T)) begin
      next_st.join_busy = 1'b0;
    end

    // clear before set, so a report landing on the finish cycle survives
    if (u_if.done && st.shot == u_if.pat.id) begin
      next_st.shot = P_NONE;
    end
    if (xfer_done) begin
      next_st.shot = P_XFER_DONE;
    end
    if (xfer_fail) begin
      next_st.shot = P_FAIL;
    end

    unique case (st.dst)
      D_IDLE: begin
        next_st.pulses = 3'h0;
        if (u_if.btn) begin
          next_st.dst = D_HIGH;
          next_st.ms  = 16'h0000;
        end
      end
      D_HIGH: begin
        if (u_if.btn) begin
          if (st.pulses == 3'h0 && st.ms >= GENKEY_T) begin
            next_st.dst = D_HOLD;
          end else if (st.pulses == 3'(`BSL_RESTORE_PULSES) && st.ms > RESTORE_T) begin
            next_st.dst = D_RESTORE;
          end
        end else if (st.ms >= BRIEF_MIN && st.ms <= BRIEF_MAX && st.pulses != 3'h7) begin
          next_st.pulses = st.pulses + 3'h1;
          next_st.dst    = D_LOW;
          next_st.ms     = 16'h0000;
        end else begin
          next_st.dst = D_LOCK;
          next_st.ms  = 16'h0000;
        end
      end
      D_LOW: begin
        if (u_if.btn) begin
          next_st.dst = (st.ms >= BRIEF_MIN) ? D_HIGH : D_LOCK;
          next_st.ms  = 16'h0000;
        end else if (st.ms > BRIEF_MAX) begin
          // a quiet gap longer than any brief low ends the sequence
          next_st.dst = D_IDLE;
          if (st.pulses == 3'h1) begin
            if (st.join_busy) begin
              next_st.join_cancel = 1'b1;
              next_st.join_busy   = 1'b0;
              next_st.shot        = P_CANCEL;
            end else begin
              next_st.join_start = 1'b1;
              next_st.join_busy  = 1'b1;
              next_st.join_ms    = 16'h0000;
            end
          end else if (st.pulses == 3'(`BSL_KEYTEST_PULSES)) begin
            next_st.key_test = 1'b1;
            next_st.shot     = keytest_id(key_set, is_admin);
          end
        end
      end
      D_LOCK: begin
        if (u_if.btn) begin
          next_st.ms = 16'h0000;
        end else if (st.ms >= LOCKOUT_T) begin
          next_st.dst = D_IDLE;
        end
      end
      D_HOLD: begin
        if (!u_if.btn) begin
          next_st.genkey = 1'b1;
          next_st.dst    = D_IDLE;
        end
      end
      D_RESTORE: begin
        if (!u_if.btn) begin
          next_st.restore = 1'b1;
          next_st.baud    = 16'(`BSL_DEFAULT_BAUD);
          next_st.dst     = D_IDLE;
        end
      end
    endcase

    // a press in progress shows steady on unless it is a held gesture, patterns next, traffic last
    if (st.dst == D_HIGH || (st.dst == D_LOCK && u_if.btn)) begin
      next_st.led = 1'b1;
    end else if (pick != P_NONE) begin
      next_st.led = u_if.led;
    end else begin
      next_st.led = pkt_activity;
    end
  end

  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      st <= '{dst: D_IDLE, ms: 16'h0000, pulses: 3'h0, div: 17'h0_0000, tick: 1'b0,
              join_busy: 1'b0, join_ms: 16'h0000, shot: P_NONE, join_start: 1'b0,
              join_cancel: 1'b0, genkey: 1'b0, key_test: 1'b0, restore: 1'b0,
              baud: 16'(`BSL_DEFAULT_BAUD), led: 1'b0};
    end else begin
      st <= next_st;
    end
  end

  assign status_indicator_line = st.led;
  assign join_start            = st.join_start;
  assign join_cancel           = st.join_cancel;
  assign genkey_commit         = st.genkey;
  assign key_test              = st.key_test;
  assign factory_restore       = st.restore;
  assign restore_baud          = st.baud;

  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!rst_n);

  sequence s_hold_release;
    st.dst == D_HOLD && !u_if.btn;
  endsequence
  sequence s_commit_pulse;
    genkey_commit ##1 !genkey_commit;
  endsequence
  sequence s_restore_release;
    st.dst == D_RESTORE && !u_if.btn;
  endsequence

  a_genkey_release: assert property (s_hold_release |=> s_commit_pulse)
    else $error("generation not committed on release");
  a_restore_commit: assert property (s_restore_release |=> factory_restore
                                     && restore_baud == 16'(`BSL_DEFAULT_BAUD))
    else $error("restore not issued with default rate");
  a_hold_pattern: assert property (st.dst == D_HOLD |-> u_if.pat.id == P_LONGHOLD)
    else $error("long hold acknowledge pattern missing");
  a_restore_groups: assert property (st.dst == D_RESTORE
                                     |-> u_if.pat.quick_n == 2'h3 && u_if.pat.reps == 3'h0)
    else $error("restore groups not of three");
  a_press_lit: assert property (st.dst == D_HIGH |=> status_indicator_line)
    else $error("indicator dark while button held");
  a_keytest_count: assert property (key_test |-> $past(st.pulses) == 3'h3
                                    && $past(st.dst) == D_LOW)
    else $error("key test without three pulses");
  a_cancel_busy: assert property (join_cancel |-> $past(st.join_busy)
                                  && !st.join_busy && st.shot == P_CANCEL)
    else $error("cancel without join in progress");
  a_lock_holds: assert property (st.dst == D_LOCK && u_if.btn
                                 |=> st.dst == D_LOCK && st.ms == 16'h0000)
    else $error("lockout left while button high");
  a_join_window: assert property (st.join_busy && st.join_ms >= JOIN_T
                                  |=> !st.join_busy)
    else $error("join search outlived its window");
endmodule
